/* File: logic/pbm_pin_mux.sv */
// Pin sharing logic for port B bits 16 through 29.
// What this block does
// - Unselected pins act as plain GPIO bits.
// - SPI out-in pin drives when master only.
// - SPI in-out pin drives when slave only.
// - Bit 27 carries two-wire data, open drain.
// - Bit 26 carries two-wire clock, open drain.
// - UART A general pin: IO, clock in, clock out.
// - UART B general pin: same three uses.
// - Bits 23, 22 are active-low clear-to-send inputs.
// - Bits 19, 18 drive active-low ready-to-send.
// - Bits 21, 20 feed UART receive data.
// - Bits 17, 16 drive UART transmit data.
`timescale 1ns/1ps

module pbm_pin_mux (
    input  wire logic                           ref_clk,
    input  wire logic                           resetn,
    input  wire logic [pbm_pkg::PBM_PINS-1:0]   pin_in,
    output logic      [pbm_pkg::PBM_PINS-1:0]   pin_out,
    output logic      [pbm_pkg::PBM_PINS-1:0]   pin_oe,
    input  wire logic [pbm_pkg::PBM_PINS-1:0]   periph_sel,
    input  wire logic [pbm_pkg::PBM_PINS-1:0]   gpio_out,
    input  wire logic [pbm_pkg::PBM_PINS-1:0]   gpio_dir,
    input  wire logic [pbm_pkg::PBM_PINS-1:0]   gpio_open_drain,
    output logic      [pbm_pkg::PBM_PINS-1:0]   gpio_in,
    input  wire pbm_pkg::pbm_spi_ctl_type       spi_ctl,
    output pbm_pkg::pbm_spi_sts_type            spi_sts,
    input  wire pbm_pkg::pbm_tw_ctl_type        tw_ctl,
    output pbm_pkg::pbm_tw_sts_type             tw_sts,
    input  wire pbm_pkg::pbm_uart_ctl_type      uart_a_ctl,
    output pbm_pkg::pbm_uart_sts_type           uart_a_sts,
    input  wire pbm_pkg::pbm_uart_ctl_type      uart_b_ctl,
    output pbm_pkg::pbm_uart_sts_type           uart_b_sts
);

    // Registered state and its next value.
    pbm_pkg::pbm_state_type s_r;
    pbm_pkg::pbm_state_type s_nxt;

    // Drive of a UART general pin for its selected use; bit 1 is the
    // output enable and bit 0 the output level.
    function automatic logic [1:0] gp_drive(
        input pbm_pkg::pbm_uart_ctl_type c
    );
        logic [1:0] d;
        d = 2'h0;
        case (c.gp_mode)
            // Plain pin owned by the UART.
            pbm_pkg::PBM_GP_IO: begin
                d = {c.gp_dir, c.gp_out};
            end
            // Clock source for the baud generator, so never driven.
            pbm_pkg::PBM_GP_BRG_IN: begin
                d = 2'h0;
            end
            // Bit clock at the chosen baud rate goes out.
            pbm_pkg::PBM_GP_BIT_OUT: begin
                d = {1'b1, c.bit_clk};
            end
            // A bad code leaves the pin released rather than fight.
            default: begin
                d = 2'h0;
            end
        endcase
        return d;
    endfunction

    // Next state: synchronise pins, then pick each pin's owner.
    always_comb begin
        logic [1:0] ga;
        logic [1:0] gb;
        s_nxt = s_r;
        ga = gp_drive(uart_a_ctl);
        gb = gp_drive(uart_b_ctl);
        // Two flops before any logic reads a pin level.
        s_nxt.sync1 = pin_in;
        s_nxt.sync2 = s_r.sync1;
        // Captured select; the mux uses the held copy.
        s_nxt.sel = periph_sel;
        // GPIO drive, with open drain releasing the pin for a one.
        s_nxt.pin_out = gpio_out;
        s_nxt.pin_oe = gpio_dir & (~gpio_open_drain | ~gpio_out);
        s_nxt.gpio_in = s_r.sync2;
        // SPI out-in data: output as master, input as slave.
        if (s_r.sel[pbm_pkg::PBM_IDX_SPI_OUT_IN]) begin
            s_nxt.pin_out[pbm_pkg::PBM_IDX_SPI_OUT_IN] = spi_ctl.out_in_data;
            s_nxt.pin_oe[pbm_pkg::PBM_IDX_SPI_OUT_IN] = spi_ctl.master;
        end
        // SPI in-out data: input as master, output as slave.
        if (s_r.sel[pbm_pkg::PBM_IDX_SPI_IN_OUT]) begin
            s_nxt.pin_out[pbm_pkg::PBM_IDX_SPI_IN_OUT] = spi_ctl.in_out_data;
            s_nxt.pin_oe[pbm_pkg::PBM_IDX_SPI_IN_OUT] = ~spi_ctl.master;
        end
        s_nxt.spi.out_in_data = s_r.sel[pbm_pkg::PBM_IDX_SPI_OUT_IN]
            & s_r.sync2[pbm_pkg::PBM_IDX_SPI_OUT_IN];
        s_nxt.spi.in_out_data = s_r.sel[pbm_pkg::PBM_IDX_SPI_IN_OUT]
            & s_r.sync2[pbm_pkg::PBM_IDX_SPI_IN_OUT];
        // Two-wire lines only ever pull low; the outside pull-up
        // makes the high level, so two drivers can never clash.
        if (s_r.sel[pbm_pkg::PBM_IDX_TW_DATA]) begin
            s_nxt.pin_out[pbm_pkg::PBM_IDX_TW_DATA] = 1'b0;
            s_nxt.pin_oe[pbm_pkg::PBM_IDX_TW_DATA] = ~tw_ctl.data_out;
        end
        if (s_r.sel[pbm_pkg::PBM_IDX_TW_CLOCK]) begin
            s_nxt.pin_out[pbm_pkg::PBM_IDX_TW_CLOCK] = 1'b0;
            s_nxt.pin_oe[pbm_pkg::PBM_IDX_TW_CLOCK] = ~tw_ctl.clock_out;
        end
        // Unrouted two-wire lines read as an idle, released bus.
        s_nxt.tw.data_in = ~s_r.sel[pbm_pkg::PBM_IDX_TW_DATA]
            | s_r.sync2[pbm_pkg::PBM_IDX_TW_DATA];
        s_nxt.tw.clock_in = ~s_r.sel[pbm_pkg::PBM_IDX_TW_CLOCK]
            | s_r.sync2[pbm_pkg::PBM_IDX_TW_CLOCK];
        // UART general pins.
        if (s_r.sel[pbm_pkg::PBM_IDX_UA_GP]) begin
            s_nxt.pin_oe[pbm_pkg::PBM_IDX_UA_GP] = ga[1];
            s_nxt.pin_out[pbm_pkg::PBM_IDX_UA_GP] = ga[0];
        end
        if (s_r.sel[pbm_pkg::PBM_IDX_UB_GP]) begin
            s_nxt.pin_oe[pbm_pkg::PBM_IDX_UB_GP] = gb[1];
            s_nxt.pin_out[pbm_pkg::PBM_IDX_UB_GP] = gb[0];
        end
        s_nxt.ua.gp_in = s_r.sel[pbm_pkg::PBM_IDX_UA_GP]
            & s_r.sync2[pbm_pkg::PBM_IDX_UA_GP];
        s_nxt.ub.gp_in = s_r.sel[pbm_pkg::PBM_IDX_UB_GP]
            & s_r.sync2[pbm_pkg::PBM_IDX_UB_GP];
        s_nxt.ua.brg_clk = s_r.sel[pbm_pkg::PBM_IDX_UA_GP]
            & (uart_a_ctl.gp_mode == pbm_pkg::PBM_GP_BRG_IN)
            & s_r.sync2[pbm_pkg::PBM_IDX_UA_GP];
        s_nxt.ub.brg_clk = s_r.sel[pbm_pkg::PBM_IDX_UB_GP]
            & (uart_b_ctl.gp_mode == pbm_pkg::PBM_GP_BRG_IN)
            & s_r.sync2[pbm_pkg::PBM_IDX_UB_GP];
        // Clear-to-send inputs; unrouted they read high, which holds
        // the transmitter off instead of letting it send blind.
        if (s_r.sel[pbm_pkg::PBM_IDX_UA_CTS]) begin
            s_nxt.pin_oe[pbm_pkg::PBM_IDX_UA_CTS] = 1'b0;
        end
        if (s_r.sel[pbm_pkg::PBM_IDX_UB_CTS]) begin
            s_nxt.pin_oe[pbm_pkg::PBM_IDX_UB_CTS] = 1'b0;
        end
        s_nxt.ua.clear_to_send_n = ~s_r.sel[pbm_pkg::PBM_IDX_UA_CTS]
            | s_r.sync2[pbm_pkg::PBM_IDX_UA_CTS];
        s_nxt.ub.clear_to_send_n = ~s_r.sel[pbm_pkg::PBM_IDX_UB_CTS]
            | s_r.sync2[pbm_pkg::PBM_IDX_UB_CTS];
        // Receive inputs; unrouted they read as the idle mark level.
        if (s_r.sel[pbm_pkg::PBM_IDX_UA_RX]) begin
            s_nxt.pin_oe[pbm_pkg::PBM_IDX_UA_RX] = 1'b0;
        end
        if (s_r.sel[pbm_pkg::PBM_IDX_UB_RX]) begin
            s_nxt.pin_oe[pbm_pkg::PBM_IDX_UB_RX] = 1'b0;
        end
        s_nxt.ua.receive_in = ~s_r.sel[pbm_pkg::PBM_IDX_UA_RX]
            | s_r.sync2[pbm_pkg::PBM_IDX_UA_RX];
        s_nxt.ub.receive_in = ~s_r.sel[pbm_pkg::PBM_IDX_UB_RX]
            | s_r.sync2[pbm_pkg::PBM_IDX_UB_RX];
        // Ready-to-send and transmit outputs are always driven.
        if (s_r.sel[pbm_pkg::PBM_IDX_UA_RTS]) begin
            s_nxt.pin_oe[pbm_pkg::PBM_IDX_UA_RTS] = 1'b1;
            s_nxt.pin_out[pbm_pkg::PBM_IDX_UA_RTS] =
                uart_a_ctl.ready_to_send_n;
        end
        if (s_r.sel[pbm_pkg::PBM_IDX_UB_RTS]) begin
            s_nxt.pin_oe[pbm_pkg::PBM_IDX_UB_RTS] = 1'b1;
            s_nxt.pin_out[pbm_pkg::PBM_IDX_UB_RTS] =
                uart_b_ctl.ready_to_send_n;
        end
        if (s_r.sel[pbm_pkg::PBM_IDX_UA_TX]) begin
            s_nxt.pin_oe[pbm_pkg::PBM_IDX_UA_TX] = 1'b1;
            s_nxt.pin_out[pbm_pkg::PBM_IDX_UA_TX] = uart_a_ctl.transmit_out;
        end
        if (s_r.sel[pbm_pkg::PBM_IDX_UB_TX]) begin
            s_nxt.pin_oe[pbm_pkg::PBM_IDX_UB_TX] = 1'b1;
            s_nxt.pin_out[pbm_pkg::PBM_IDX_UB_TX] = uart_b_ctl.transmit_out;
        end
    end

    // State register; reset gives GPIO inputs on every pin.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= pbm_pkg::PBM_STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Every output comes straight from the state register.
    assign pin_out    = s_r.pin_out;
    assign pin_oe     = s_r.pin_oe;
    assign gpio_in    = s_r.gpio_in;
    assign spi_sts    = s_r.spi;
    assign tw_sts     = s_r.tw;
    assign uart_a_sts = s_r.ua;
    assign uart_b_sts = s_r.ub;

    // Checks on the pin ownership.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_gpio_plain_drive: assert property (
        (s_r.sel == '0 && gpio_open_drain == '0) |=>
        (pin_out == $past(gpio_out) && pin_oe == $past(gpio_dir)))
        else $error("GPIO drive not followed");
    a_spi_oi_dir: assert property (
        s_r.sel[pbm_pkg::PBM_IDX_SPI_OUT_IN] |=>
        pin_oe[pbm_pkg::PBM_IDX_SPI_OUT_IN] == $past(spi_ctl.master))
        else $error("SPI out-in direction wrong");
    a_spi_io_dir: assert property (
        s_r.sel[pbm_pkg::PBM_IDX_SPI_IN_OUT] |=>
        pin_oe[pbm_pkg::PBM_IDX_SPI_IN_OUT] != $past(spi_ctl.master))
        else $error("SPI in-out direction wrong");
    a_tw_data_drain: assert property (
        s_r.sel[pbm_pkg::PBM_IDX_TW_DATA] |=>
        (!pin_out[pbm_pkg::PBM_IDX_TW_DATA] &&
         pin_oe[pbm_pkg::PBM_IDX_TW_DATA] == !$past(tw_ctl.data_out)))
        else $error("Two-wire data not open drain");
    a_tw_clock_drain: assert property (
        s_r.sel[pbm_pkg::PBM_IDX_TW_CLOCK] |=>
        (!pin_out[pbm_pkg::PBM_IDX_TW_CLOCK] &&
         pin_oe[pbm_pkg::PBM_IDX_TW_CLOCK] == !$past(tw_ctl.clock_out)))
        else $error("Two-wire clock not open drain");
    a_ua_bit_clock: assert property (
        (s_r.sel[pbm_pkg::PBM_IDX_UA_GP] &&
         uart_a_ctl.gp_mode == pbm_pkg::PBM_GP_BIT_OUT) |=>
        (pin_oe[pbm_pkg::PBM_IDX_UA_GP] &&
         pin_out[pbm_pkg::PBM_IDX_UA_GP] == $past(uart_a_ctl.bit_clk)))
        else $error("UART A bit clock not driven");
    a_ub_brg_in: assert property (
        (s_r.sel[pbm_pkg::PBM_IDX_UB_GP] &&
         uart_b_ctl.gp_mode == pbm_pkg::PBM_GP_BRG_IN) |=>
        (!pin_oe[pbm_pkg::PBM_IDX_UB_GP] && uart_b_sts.brg_clk ==
         $past(s_r.sync2[pbm_pkg::PBM_IDX_UB_GP])))
        else $error("UART B clock source wrong");
    a_ua_cts_route: assert property (
        s_r.sel[pbm_pkg::PBM_IDX_UA_CTS] [*3] |=>
        (!pin_oe[pbm_pkg::PBM_IDX_UA_CTS] && uart_a_sts.clear_to_send_n ==
         $past(pin_in[pbm_pkg::PBM_IDX_UA_CTS], 3)))
        else $error("UART A clear-to-send wrong");
    a_ub_rts_drive: assert property (
        s_r.sel[pbm_pkg::PBM_IDX_UB_RTS] |=>
        (pin_oe[pbm_pkg::PBM_IDX_UB_RTS] && pin_out[pbm_pkg::PBM_IDX_UB_RTS]
         == $past(uart_b_ctl.ready_to_send_n)))
        else $error("UART B ready-to-send wrong");
    a_ua_rx_route: assert property (
        s_r.sel[pbm_pkg::PBM_IDX_UA_RX] [*3] |=>
        uart_a_sts.receive_in == $past(pin_in[pbm_pkg::PBM_IDX_UA_RX], 3))
        else $error("UART A receive path wrong");
    a_ub_tx_drive: assert property (
        s_r.sel[pbm_pkg::PBM_IDX_UB_TX] |=>
        (pin_oe[pbm_pkg::PBM_IDX_UB_TX] && pin_out[pbm_pkg::PBM_IDX_UB_TX]
         == $past(uart_b_ctl.transmit_out)))
        else $error("UART B transmit not driven");
    a_reset_gpio_in: assert property (
        @(posedge ref_clk) disable iff (1'b0)
        !resetn |-> (s_r.sel == '0 && pin_oe == '0))
        else $error("Reset did not release the pins");

    c_spi_master: cover property (
        s_r.sel[pbm_pkg::PBM_IDX_SPI_OUT_IN] && spi_ctl.master);
    c_tw_low: cover property (
        s_r.sel[pbm_pkg::PBM_IDX_TW_DATA] && !tw_ctl.data_out);
    c_ua_bit_out: cover property (
        s_r.sel[pbm_pkg::PBM_IDX_UA_GP] &&
        uart_a_ctl.gp_mode == pbm_pkg::PBM_GP_BIT_OUT);
    c_ub_rx_fall: cover property (
        s_r.sel[pbm_pkg::PBM_IDX_UB_RX] && $fell(uart_b_sts.receive_in));

endmodule

/* File: pkg/pbm_pkg.sv */
// Shared types and constants for the port B upper pin sharing block.
package pbm_pkg;

    // Number of shared pins, port B bits 16 through 29.
    localparam int PBM_PINS = 14;
    // Port B index of the lowest shared pin.
    localparam int PBM_PIN_BASE = 16;

    // Vector positions of each pin: port B bit minus the base.
    localparam int PBM_IDX_SPI_OUT_IN = 29 - PBM_PIN_BASE;
    localparam int PBM_IDX_SPI_IN_OUT = 28 - PBM_PIN_BASE;
    localparam int PBM_IDX_TW_DATA    = 27 - PBM_PIN_BASE;
    localparam int PBM_IDX_TW_CLOCK   = 26 - PBM_PIN_BASE;
    localparam int PBM_IDX_UA_GP      = 25 - PBM_PIN_BASE;
    localparam int PBM_IDX_UB_GP      = 24 - PBM_PIN_BASE;
    localparam int PBM_IDX_UA_CTS     = 23 - PBM_PIN_BASE;
    localparam int PBM_IDX_UB_CTS     = 22 - PBM_PIN_BASE;
    localparam int PBM_IDX_UA_RX      = 21 - PBM_PIN_BASE;
    localparam int PBM_IDX_UB_RX      = 20 - PBM_PIN_BASE;
    localparam int PBM_IDX_UA_RTS     = 19 - PBM_PIN_BASE;
    localparam int PBM_IDX_UB_RTS     = 18 - PBM_PIN_BASE;
    localparam int PBM_IDX_UA_TX      = 17 - PBM_PIN_BASE;
    localparam int PBM_IDX_UB_TX      = 16 - PBM_PIN_BASE;

    // Use of a UART general pin, one-hot coded.
    typedef enum logic [2:0] {
        PBM_GP_IO      = 3'h1,
        PBM_GP_BRG_IN  = 3'h2,
        PBM_GP_BIT_OUT = 3'h4
    } pbm_gp_mode_type;

    // Controls from the serial peripheral controller.
    typedef struct packed {
        logic master;
        logic out_in_data;
        logic in_out_data;
    } pbm_spi_ctl_type;

    // Data delivered to the serial peripheral controller.
    typedef struct packed {
        logic out_in_data;
        logic in_out_data;
    } pbm_spi_sts_type;

    // Two-wire controller: a 0 pulls the line low, a 1 releases it.
    typedef struct packed {
        logic data_out;
        logic clock_out;
    } pbm_tw_ctl_type;

    // Two-wire line levels as seen by the controller.
    typedef struct packed {
        logic data_in;
        logic clock_in;
    } pbm_tw_sts_type;

    // Controls from one UART.
    typedef struct packed {
        pbm_gp_mode_type gp_mode;
        logic            gp_out;
        logic            gp_dir;
        logic            bit_clk;
        logic            transmit_out;
        logic            ready_to_send_n;
    } pbm_uart_ctl_type;

    // Signals delivered to one UART.
    typedef struct packed {
        logic gp_in;
        logic brg_clk;
        logic receive_in;
        logic clear_to_send_n;
    } pbm_uart_sts_type;

    // The whole state of the pin sharing block.
    typedef struct packed {
        logic [PBM_PINS-1:0] sync1;
        logic [PBM_PINS-1:0] sync2;
        logic [PBM_PINS-1:0] sel;
        logic [PBM_PINS-1:0] pin_out;
        logic [PBM_PINS-1:0] pin_oe;
        logic [PBM_PINS-1:0] gpio_in;
        pbm_spi_sts_type     spi;
        pbm_tw_sts_type      tw;
        pbm_uart_sts_type    ua;
        pbm_uart_sts_type    ub;
    } pbm_state_type;

    // Reset values: lines released, UART inputs at their idle levels.
    localparam pbm_spi_sts_type PBM_SPI_STS_RST = 2'h0;
    localparam pbm_tw_sts_type PBM_TW_STS_RST = 2'h3;
    localparam pbm_uart_sts_type PBM_UART_STS_RST = 4'h3;
    localparam logic [PBM_PINS-1:0] PBM_VEC_RST = 14'h0000;
    localparam pbm_state_type PBM_STATE_RST = '{
        sync1: PBM_VEC_RST, sync2: PBM_VEC_RST, sel: PBM_VEC_RST,
        pin_out: PBM_VEC_RST, pin_oe: PBM_VEC_RST, gpio_in: PBM_VEC_RST,
        spi: PBM_SPI_STS_RST, tw: PBM_TW_STS_RST,
        ua: PBM_UART_STS_RST, ub: PBM_UART_STS_RST};

endpackage

/* File: tb/pbm_far_side_model.sv */
// Far side model: external serial devices and pad wiring of bits 16..29.
`timescale 1ns/1ps

module pbm_far_side_model (
    input  wire logic                         ref_clk,
    input  wire logic [pbm_pkg::PBM_PINS-1:0] pin_out,
    input  wire logic [pbm_pkg::PBM_PINS-1:0] pin_oe,
    input  wire logic [pbm_pkg::PBM_PINS-1:0] ext_en,
    input  wire logic [pbm_pkg::PBM_PINS-1:0] ext_val,
    output logic      [pbm_pkg::PBM_PINS-1:0] pin_in
);
    // Two-wire lines are open drain with a pull-up on the board.
    localparam logic [13:0] OD_MASK = 14'h0C00;
    // A released push-pull line changes every cycle, so that a stale
    // value never reads as a valid one.
    logic [pbm_pkg::PBM_PINS-1:0] float_r = 14'h0000;

    // The floating pattern toggles on every clock.
    always @(posedge ref_clk) begin
        float_r <= ~float_r;
    end

    // Each pad resolves the device drive against the external device.
    always_comb begin
        for (int i = 0; i < pbm_pkg::PBM_PINS; i++) begin
            if (OD_MASK[i]) begin
                // Either party may only pull low; nobody drives high.
                pin_in[i] = !((pin_oe[i] && !pin_out[i]) ||
                              (ext_en[i] && !ext_val[i]));
            end else if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                // Clear-to-send, receive and slave data come from here.
                pin_in[i] = ext_val[i];
            end else begin
                pin_in[i] = float_r[i];
            end
        end
    end
endmodule

/* File: tb/pbm_pin_mux_bench.sv */
// Self-checking bench for the port B upper pin sharing block.
`timescale 1ns/1ps

module pbm_pin_mux_bench;
    localparam int N = pbm_pkg::PBM_PINS;
    logic                       ref_clk = 1'b0;
    logic                       resetn = 1'b1;
    logic [N-1:0]               pin_in, pin_out, pin_oe, g_in;
    logic [N-1:0]               sel, g_out, g_dir, g_od, ext_en, ext_val;
    pbm_pkg::pbm_spi_ctl_type   spi_ctl;
    pbm_pkg::pbm_spi_sts_type   spi_sts;
    pbm_pkg::pbm_tw_ctl_type    tw_ctl;
    pbm_pkg::pbm_tw_sts_type    tw_sts;
    pbm_pkg::pbm_uart_ctl_type  ua_ctl, ub_ctl;
    pbm_pkg::pbm_uart_sts_type  ua_sts, ub_sts;
    int                         n_mismatch = 0;
    int                         compares = 0;
    int                         cycles = 0;

    // A 125 MHz clock.
    always #4 ref_clk = ~ref_clk;

    pbm_pin_mux dut (.ref_clk(ref_clk), .resetn(resetn), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .periph_sel(sel),
        .gpio_out(g_out), .gpio_dir(g_dir), .gpio_open_drain(g_od),
        .gpio_in(g_in), .spi_ctl(spi_ctl), .spi_sts(spi_sts),
        .tw_ctl(tw_ctl), .tw_sts(tw_sts), .uart_a_ctl(ua_ctl),
        .uart_a_sts(ua_sts), .uart_b_ctl(ub_ctl), .uart_b_sts(ub_sts));

    pbm_far_side_model far (.ref_clk(ref_clk), .pin_out(pin_out),
        .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Waits past the select register, the output flop and the three-flop
    // input path, so a pad turned round by a new select reads back too.
    task automatic settle();
        repeat (6) @(posedge ref_clk);
        #1;
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic finish_test();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Plain GPIO outputs, one open-drain bit, then GPIO inputs.
    task automatic t_gpio();
        @(posedge ref_clk);
        g_dir <= 14'h3FFF;
        g_out <= 14'h2A5B;
        g_od  <= 14'h0001;
        settle();
        chk(16'(pin_oe), 16'h3FFE);
        chk(16'(pin_out[13:1]), 16'h152D);
        @(posedge ref_clk);
        g_dir   <= 14'h0000;
        g_od    <= 14'h0000;
        ext_en  <= 14'h3FFF;
        ext_val <= 14'h15A4;
        settle();
        chk(16'(pin_oe), 16'h0000);
        chk(16'(g_in), 16'h15A4);
    endtask

    // SPI data pins swap direction with master and slave mode.
    task automatic t_spi();
        for (int m = 0; m < 2; m++) begin
            @(posedge ref_clk);
            sel     <= 14'h3000;
            ext_val <= 14'h3000;
            spi_ctl <= '{master: m[0], out_in_data: 1'b0, in_out_data: 1'b0};
            settle();
            chk(16'(pin_oe[13:12]), m ? 16'h0002 : 16'h0001);
            chk(16'(spi_sts), m ? 16'h0001 : 16'h0002);
        end
    endtask

    // Two-wire lines only pull low and read the wired level back.
    task automatic t_two_wire();
        for (int d = 0; d < 2; d++) begin
            @(posedge ref_clk);
            sel    <= 14'h0C00;
            ext_en <= 14'h0000;
            tw_ctl <= '{data_out: d[0], clock_out: 1'b1};
            settle();
            chk(16'(pin_oe[11:10]), d ? 16'h0000 : 16'h0002);
            chk(16'(tw_sts), d ? 16'h0003 : 16'h0001);
        end
        @(posedge ref_clk);
        ext_en  <= 14'h0400;
        ext_val <= 14'h0000;
        settle();
        chk(16'(tw_sts), 16'h0002);
    endtask

    // Every use of both UART general pins, plus a code that means none,
    // which must leave the pin released.
    task automatic t_general();
        pbm_pkg::pbm_uart_ctl_type c;
        pbm_pkg::pbm_gp_mode_type  md [4];
        int                        ix;
        logic [3:0]                exp_oe;
        md = '{pbm_pkg::PBM_GP_IO, pbm_pkg::PBM_GP_BRG_IN,
               pbm_pkg::PBM_GP_BIT_OUT, pbm_pkg::pbm_gp_mode_type'(3'h0)};
        exp_oe = 4'h5;
        for (int u = 0; u < 2; u++) begin
            ix = u ? pbm_pkg::PBM_IDX_UB_GP : pbm_pkg::PBM_IDX_UA_GP;
            for (int k = 0; k < 4; k++) begin
                c = '{gp_mode: md[k], gp_out: 1'b1, gp_dir: 1'b1,
                      bit_clk: 1'b0, transmit_out: 1'b1,
                      ready_to_send_n: 1'b1};
                @(posedge ref_clk);
                sel        <= N'(1) << ix;
                ext_en     <= N'(1) << ix;
                ext_val    <= N'(1) << ix;
                if (u) ub_ctl <= c;
                else ua_ctl <= c;
                settle();
                chk(16'(pin_oe[ix]), 16'(exp_oe[k]));
                chk(16'(pin_out[ix] | !pin_oe[ix]), 16'(k != 2));
                chk(16'(u ? ub_sts[3:2] : ua_sts[3:2]),
                    16'(k == 2 ? 0 : (k == 1 ? 3 : 2)));
            end
        end
    endtask

    // Clear-to-send, receive, ready-to-send and transmit of both UARTs.
    task automatic t_lines();
        for (int v = 0; v < 2; v++) begin
            @(posedge ref_clk);
            sel     <= 14'h00FF;
            ext_en  <= 14'h00F0;
            ext_val <= v ? 14'h0090 : 14'h0060;
            ua_ctl.transmit_out    <= v[0];
            ua_ctl.ready_to_send_n <= !v[0];
            ub_ctl.transmit_out    <= !v[0];
            ub_ctl.ready_to_send_n <= v[0];
            settle();
            chk(16'(ua_sts[1:0]), v ? 16'h0001 : 16'h0002);
            chk(16'(ub_sts[1:0]), v ? 16'h0002 : 16'h0001);
            chk(16'(pin_oe[7:0]), 16'h000F);
            chk(16'(pin_out[3:0]), v ? 16'h0006 : 16'h0009);
        end
    endtask

    // Cuts a hung run short.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            finish_test();
        end
    end

    // Main sequence: reset, check reset state, then each scenario.
    initial begin
        // A non-blocking fall lets the reset process see the edge at
        // time zero, after it has started waiting for it.
        resetn <= 1'b0;
        {sel, g_out, g_dir, g_od, ext_en, ext_val} = '0;
        spi_ctl = '0;
        tw_ctl = 2'h3;
        ua_ctl = '{gp_mode: pbm_pkg::PBM_GP_IO, default: 1'b1};
        ub_ctl = '{gp_mode: pbm_pkg::PBM_GP_IO, default: 1'b1};
        repeat (20) @(posedge ref_clk);
        #1;
        chk(16'(pin_oe), 16'h0000);
        chk(16'({tw_sts, ua_sts, ub_sts}), 16'h0333);
        @(posedge ref_clk);
        resetn <= 1'b1;
        settle();
        chk(16'(pin_oe), 16'h0000);
        t_gpio();
        t_spi();
        t_two_wire();
        t_general();
        t_lines();
        // A reset in mid-run must drop every pin back to a GPIO input.
        @(posedge ref_clk);
        resetn <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(16'(pin_oe), 16'h0000);
        chk(16'({tw_sts, ua_sts, ub_sts}), 16'h0333);
        @(posedge ref_clk);
        resetn <= 1'b1;
        settle();
        chk(16'(pin_oe[7:0]), 16'h000F);
        finish_test();
    end
endmodule
